/* burst_sram_buf.sv */
// small valid/ready buffer for read lines
`timescale 1ns/1ps
module burst_sram_buf #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 2
) (
    // clock
    input wire logic clk,
    input wire logic rst_b,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] store_r [0:DEPTH-1];
    logic [PW-1:0] wp_r;
    logic [PW-1:0] rp_r;
    logic [PW:0] cnt_r;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (cnt_r != (PW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = store_r[rp_r];

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            store_r[wp_r] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            if (push)
            begin
                wp_r <= (wp_r == PW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            end
            if (pop)
            begin
                rp_r <= (rp_r == PW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule

/* burst_sram_mem.sv */
// line memory with byte enables and registered read data
`timescale 1ns/1ps
module burst_sram_mem #(
    parameter int ADDR_W = 20,
    parameter int DATA_W = 36,
    parameter int BYTES = 4
) (
    // clock
    input wire logic clk,
    input wire logic rst_b,
    // access
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [BYTES-1:0] be,
    // read answer
    output logic [DATA_W-1:0] rdata,
    output logic rvalid
);
    localparam int BW = DATA_W / BYTES;
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    always_ff @(posedge clk)
    begin
        for (int i = 0; i < BYTES; i++)
        begin
            if (wr_en && be[i])
            begin
                mem[addr][i*BW +: BW] <= wdata[i*BW +: BW];
            end
        end
        if (rd_en)
        begin
            rdata <= mem[addr];
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rvalid <= 1'b0;
        end
        else
        begin
            rvalid <= rd_en && !wr_en;
        end
    end
endmodule

/* burst_sram_pkg.sv */
// shared constants and carrier types for the burst sram port
package burst_sram_pkg;
    // default geometry: narrow configuration
    localparam int WORD_W_DEF = 18;
    localparam int DEPTH_WORDS_DEF = 2097152;
    localparam int BYTE_W = 9;
    localparam int BURST_LEN = 2;
    // read latency in positive link clock cycles
    localparam int RD_LAT_K = 2;
    // synchroniser depth for pin inputs
    localparam int SYNC_STAGES = 2;
    // two-entry buffer in the read path
    localparam int RBUF_DEPTH = 2;
    // link clock period in the bench, in ns, and the local clock period
    localparam int LINK_PERIOD_NS = 80;
    localparam int CLK_PERIOD_NS = 4;
    localparam int LINK_PERIOD_CYC = LINK_PERIOD_NS / CLK_PERIOD_NS;

    // control pins sampled together
    typedef struct packed {
        logic k;
        logic k_n;
        logic load_strobe_n;
        logic rd_wr;
    } link_ctl_s;

    typedef enum logic [1:0] {
        WR_IDLE,
        WR_BEAT0,
        WR_BEAT1,
        WR_COMMIT
    } wr_state_e;
endpackage

/* burst_sram_port.sv */
// burst sram port: ddr pin side, write assembly, read pipeline
// Functional notes
// - address taken on alternate positive link edges
// - write words captured on both link edges
// - read words launched on both link edges
// - each address holds two consecutive burst words
// - first read word two link cycles later
// - read valid flag marks driven read data
// - shared data pins, controller releases on reads
// - echo clocks aligned with output data
// - every input registered at link edges
// - data outputs come from link-edge registers
// - array write self-timed after second word
// - depth sets line address width
// - byte selects per word, deselected bytes kept
// - data pins released when no read
`timescale 1ns/1ps
module burst_sram_port #(
    parameter int WORD_W = burst_sram_pkg::WORD_W_DEF,
    parameter int DEPTH_WORDS = burst_sram_pkg::DEPTH_WORDS_DEF,
    parameter int ADDR_W = $clog2(DEPTH_WORDS / burst_sram_pkg::BURST_LEN)
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // link clocks from the controller
    input wire logic k,
    input wire logic k_n,
    // command pins
    input wire logic load_strobe_n,
    input wire logic rd_wr,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [WORD_W/burst_sram_pkg::BYTE_W-1:0] byte_write_select_n,
    // shared data pins
    input wire logic [WORD_W-1:0] dq_in,
    output logic [WORD_W-1:0] dq_out,
    output logic dq_oe,
    // echo clocks and valid
    output logic echo_clock,
    output logic echo_clock_n,
    output logic read_valid_flag
);
    localparam int NB = WORD_W / burst_sram_pkg::BYTE_W;
    localparam int LINE_W = WORD_W * burst_sram_pkg::BURST_LEN;
    localparam int SS = burst_sram_pkg::SYNC_STAGES;
    localparam int LAT = burst_sram_pkg::RD_LAT_K;

    // pin synchronisers: every pin goes through the same depth so edges and data stay aligned
    burst_sram_pkg::link_ctl_s ctl_pin;
    burst_sram_pkg::link_ctl_s ctl_sync_r [0:SS-1];
    logic [ADDR_W-1:0] addr_sync_r [0:SS-1];
    logic [NB-1:0] bws_sync_r [0:SS-1];
    logic [WORD_W-1:0] dq_sync_r [0:SS-1];
    logic k_d_r;
    logic kn_d_r;

    assign ctl_pin = '{k: k, k_n: k_n, load_strobe_n: load_strobe_n, rd_wr: rd_wr};

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < SS; i++)
            begin
                ctl_sync_r[i] <= '{k: 1'b0, k_n: 1'b0, load_strobe_n: 1'b1, rd_wr: 1'b1};
                addr_sync_r[i] <= '0;
                bws_sync_r[i] <= '1;
                dq_sync_r[i] <= '0;
            end
            k_d_r <= 1'b0;
            kn_d_r <= 1'b0;
        end
        else
        begin
            ctl_sync_r[0] <= ctl_pin;
            addr_sync_r[0] <= addr;
            bws_sync_r[0] <= byte_write_select_n;
            dq_sync_r[0] <= dq_in;
            for (int i = 1; i < SS; i++)
            begin
                ctl_sync_r[i] <= ctl_sync_r[i-1];
                addr_sync_r[i] <= addr_sync_r[i-1];
                bws_sync_r[i] <= bws_sync_r[i-1];
                dq_sync_r[i] <= dq_sync_r[i-1];
            end
            k_d_r <= ctl_sync_r[SS-1].k;
            kn_d_r <= ctl_sync_r[SS-1].k_n;
        end
    end

    // edge detection and decode
    wire burst_sram_pkg::link_ctl_s ctl_s = ctl_sync_r[SS-1];
    wire k_rise = ctl_s.k && !k_d_r;
    wire kn_rise = ctl_s.k_n && !kn_d_r;
    logic addr_busy_r;
    wire load_edge = k_rise && !ctl_s.load_strobe_n && !addr_busy_r;
    wire load_rd = load_edge && ctl_s.rd_wr;
    wire load_wr = load_edge && !ctl_s.rd_wr;

    // write assembly
    burst_sram_pkg::wr_state_e wr_state_r;
    burst_sram_pkg::wr_state_e wr_state_nxt;
    logic [ADDR_W-1:0] wr_addr_r;
    logic [LINE_W-1:0] wr_line_r;
    logic [2*NB-1:0] wr_be_r;
    logic [ADDR_W-1:0] rd_addr_r;
    logic rd_issue_r;

    always_comb
    begin
        wr_state_nxt = wr_state_r;
        unique case (wr_state_r)
            burst_sram_pkg::WR_IDLE: if (load_wr) wr_state_nxt = burst_sram_pkg::WR_BEAT0;
            burst_sram_pkg::WR_BEAT0: if (k_rise) wr_state_nxt = burst_sram_pkg::WR_BEAT1;
            burst_sram_pkg::WR_BEAT1: if (kn_rise) wr_state_nxt = burst_sram_pkg::WR_COMMIT;
            burst_sram_pkg::WR_COMMIT: wr_state_nxt = burst_sram_pkg::WR_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_state_r <= burst_sram_pkg::WR_IDLE;
            addr_busy_r <= 1'b0;
            wr_addr_r <= '0;
            wr_line_r <= '0;
            wr_be_r <= '0;
        end
        else
        begin
            wr_state_r <= wr_state_nxt;
            if (load_edge)
            begin
                addr_busy_r <= 1'b1;
            end
            else if (k_rise)
            begin
                addr_busy_r <= 1'b0;
            end
            if (load_wr)
            begin
                wr_addr_r <= ctl_addr(addr_sync_r[SS-1]);
            end
            if (wr_state_r == burst_sram_pkg::WR_BEAT0 && k_rise)
            begin
                wr_line_r[WORD_W-1:0] <= dq_sync_r[SS-1];
                wr_be_r[NB-1:0] <= ~bws_sync_r[SS-1];
            end
            if (wr_state_r == burst_sram_pkg::WR_BEAT1 && kn_rise)
            begin
                wr_line_r[LINE_W-1:WORD_W] <= dq_sync_r[SS-1];
                wr_be_r[2*NB-1:NB] <= ~bws_sync_r[SS-1];
            end
        end
    end

    function automatic logic [ADDR_W-1:0] ctl_addr(input logic [ADDR_W-1:0] a);
        ctl_addr = a;
    endfunction

    // line memory: write commit wins the port, a pending read retries next cycle
    wire mem_wr = (wr_state_r == burst_sram_pkg::WR_COMMIT);
    logic rbuf_in_ready;
    logic mem_rvalid;
    logic [LINE_W-1:0] mem_rdata;
    wire mem_rd = rd_issue_r && rbuf_in_ready && !mem_wr && !mem_rvalid;
    wire [ADDR_W-1:0] mem_addr = mem_wr ? wr_addr_r : rd_addr_r;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_issue_r <= 1'b0;
            rd_addr_r <= '0;
        end
        else if (load_rd)
        begin
            rd_issue_r <= 1'b1;
            rd_addr_r <= addr_sync_r[SS-1];
        end
        else if (mem_rd)
        begin
            rd_issue_r <= 1'b0;
        end
    end

    burst_sram_mem #(
        .ADDR_W(ADDR_W),
        .DATA_W(LINE_W),
        .BYTES(2*NB)
    ) u_mem (
        .clk(clk),
        .rst_b(rst_b),
        .wr_en(mem_wr),
        .rd_en(mem_rd),
        .addr(mem_addr),
        .wdata(wr_line_r),
        .be(wr_be_r),
        .rdata(mem_rdata),
        .rvalid(mem_rvalid)
    );

    // read line buffer between array and pins
    logic rbuf_out_valid;
    logic [LINE_W-1:0] rbuf_out_data;
    logic [LAT-1:0] rd_pend_r;
    wire launch = k_rise && rd_pend_r[LAT-1];
    wire rbuf_pop = launch;

    burst_sram_buf #(
        .WIDTH(LINE_W),
        .DEPTH(burst_sram_pkg::RBUF_DEPTH)
    ) u_rbuf (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(mem_rvalid),
        .in_ready(rbuf_in_ready),
        .in_data(mem_rdata),
        .out_valid(rbuf_out_valid),
        .out_ready(rbuf_pop),
        .out_data(rbuf_out_data)
    );

    // output stage; registers update on the clk after a detected link edge
    logic [WORD_W-1:0] dq_out_r;
    logic [WORD_W-1:0] hi_word_r;
    logic second_r;
    logic dq_oe_r;
    logic valid_r;
    logic echo_r;
    logic echo_n_r;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_pend_r <= '0;
            dq_out_r <= '0;
            hi_word_r <= '0;
            second_r <= 1'b0;
            dq_oe_r <= 1'b0;
            valid_r <= 1'b0;
            echo_r <= 1'b0;
            echo_n_r <= 1'b0;
        end
        else
        begin
            echo_r <= ctl_s.k;
            echo_n_r <= ctl_s.k_n;
            if (k_rise)
            begin
                rd_pend_r <= {rd_pend_r[LAT-2:0], load_rd};
            end
            if (launch)
            begin
                dq_out_r <= rbuf_out_data[WORD_W-1:0];
                hi_word_r <= rbuf_out_data[LINE_W-1:WORD_W];
                second_r <= 1'b1;
                dq_oe_r <= 1'b1;
                valid_r <= rbuf_out_valid;
            end
            else if (kn_rise && second_r)
            begin
                dq_out_r <= hi_word_r;
                second_r <= 1'b0;
            end
            else if (k_rise)
            begin
                dq_oe_r <= 1'b0;
                valid_r <= 1'b0;
            end
        end
    end

    // echo clocks come from the same register stage as the data, keeping them matched
    assign dq_out = dq_out_r;
    assign dq_oe = dq_oe_r;
    assign read_valid_flag = valid_r;
    assign echo_clock = echo_r;
    assign echo_clock_n = echo_n_r;
endmodule

/* burst_sram_port_asserts.sv */
// pin-level assertions for the burst sram port
`timescale 1ns/1ps
module burst_sram_port_asserts #(
    parameter int WORD_W = 18,
    parameter int DEPTH_WORDS = 64,
    parameter int ADDR_W = 5
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // link side
    input wire logic k,
    input wire logic k_n,
    input wire logic load_strobe_n,
    input wire logic rd_wr,
    // read side
    input wire logic [WORD_W-1:0] dq_out,
    input wire logic dq_oe,
    input wire logic echo_clock,
    input wire logic echo_clock_n,
    input wire logic read_valid_flag
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    property p_vld_oe;
        read_valid_flag |-> dq_oe;
    endproperty
    a_vld_oe: assert property (p_vld_oe) else $error("valid flag without driven data");
    property p_echo_k;
        $rose(k) |-> ##[2:4] $rose(echo_clock);
    endproperty
    a_echo_k: assert property (p_echo_k) else $error("echo clock lost positive edge");
    property p_echo_kn;
        $rose(k_n) |-> ##[2:4] $rose(echo_clock_n);
    endproperty
    a_echo_kn: assert property (p_echo_kn) else $error("echo clock lost complementary edge");
    property p_dq_edge;
        dq_oe && $past(dq_oe) && $changed(dq_out) |-> $changed(echo_clock);
    endproperty
    a_dq_edge: assert property (p_dq_edge) else $error("read data moved off a link edge");
    property p_oe_off;
        $fell(dq_oe) |-> $rose(echo_clock);
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("drive released off a positive edge");
    property p_oe_len;
        $rose(dq_oe) |-> dq_oe [*8];
    endproperty
    a_oe_len: assert property (p_oe_len) else $error("read drive too short");
    property p_rd_lat;
        $rose(k) && !load_strobe_n && rd_wr |-> ##[40:44] dq_oe;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read data late");
    property p_wr_quiet;
        $rose(k) && !load_strobe_n && !rd_wr && !dq_oe |-> ##24 !dq_oe [*8];
    endproperty
    a_wr_quiet: assert property (p_wr_quiet) else $error("data pins driven in a write");
endmodule
bind burst_sram_port burst_sram_port_asserts #(.WORD_W(WORD_W), .DEPTH_WORDS(DEPTH_WORDS), .ADDR_W(ADDR_W)) chk (
    .clk(clk), .rst_b(rst_b), .k(k), .k_n(k_n), .load_strobe_n(load_strobe_n), .rd_wr(rd_wr),
    .dq_out(dq_out), .dq_oe(dq_oe), .echo_clock(echo_clock), .echo_clock_n(echo_clock_n),
    .read_valid_flag(read_valid_flag));

/* link_ctrl_model.sv */
// memory controller model driving the link pins
`timescale 1ns/1ps
module link_ctrl_model #(
    parameter int WORD_W = 18,
    parameter int ADDR_W = 5
) (
    // clock
    input wire logic clk,
    // driven pins
    output logic k,
    output logic k_n,
    output logic load_strobe_n,
    output logic rd_wr,
    output logic [ADDR_W-1:0] addr,
    output logic [WORD_W/burst_sram_pkg::BYTE_W-1:0] byte_write_select_n,
    output logic [WORD_W-1:0] dq_drv,
    // read side
    input wire logic [WORD_W-1:0] dq_out,
    input wire logic dq_oe,
    input wire logic read_valid_flag
);
    initial
    begin
        k = 0;
        k_n = 1;
        load_strobe_n = 1;
        rd_wr = 1;
        addr = '0;
        byte_write_select_n = '1;
        dq_drv = '0;
        forever
        begin
            repeat (burst_sram_pkg::LINK_PERIOD_CYC / 2) @(negedge clk);
            k = ~k;
            k_n = ~k_n;
        end
    end
    // load set up half a period early so sync jitter cannot split it
    task automatic cmd(input logic rd, input logic [ADDR_W-1:0] a, input logic twice);
        @(posedge k_n);
        @(negedge clk);
        load_strobe_n = 0;
        rd_wr = rd;
        addr = a;
        @(posedge k);
        @(posedge k_n);
        @(negedge clk);
        if (twice)
        begin
            addr = a + 1'b1;
            @(posedge k);
            @(posedge k_n);
            @(negedge clk);
        end
        load_strobe_n = 1;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [2*WORD_W-1:0] d, input logic [1:0] m0,
        input logic [1:0] m1);
        cmd(1'b0, a, 1'b0);
        dq_drv = d[WORD_W-1:0];
        byte_write_select_n = m0;
        @(posedge k);
        repeat (6) @(negedge clk);
        dq_drv = d[2*WORD_W-1:WORD_W];
        byte_write_select_n = m1;
        @(posedge k_n);
        repeat (6) @(negedge clk);
        dq_drv = ~dq_drv;
        byte_write_select_n = '1;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic twice, output logic [2*WORD_W-1:0] d,
        output logic [2:0] st);
        cmd(1'b1, a, twice);
        dq_drv = ~dq_drv;
        if (!twice)
            @(posedge k);
        @(posedge k);
        repeat (6) @(negedge clk);
        d[WORD_W-1:0] = dq_out;
        st[2] = dq_oe & read_valid_flag;
        @(posedge k_n);
        repeat (6) @(negedge clk);
        d[2*WORD_W-1:WORD_W] = dq_out;
        st[1] = dq_oe & read_valid_flag;
        @(posedge k);
        repeat (6) @(negedge clk);
        st[0] = dq_oe | read_valid_flag;
    endtask
endmodule

/* tb_top.sv */
// testbench for the burst sram port
`timescale 1ns/1ps
module tb_top;
    localparam int W = 18;
    logic clk, rst_b, k, k_n, load_strobe_n, rd_wr, dq_oe, echo_clock, echo_clock_n, read_valid_flag;
    logic [4:0] addr;
    logic [1:0] byte_write_select_n;
    logic [W-1:0] dq_drv, dq_in, dq_out;
    int err_count, n_tests, cyc;
    assign dq_in = dq_oe ? dq_out : dq_drv;
    burst_sram_port #(.WORD_W(W), .DEPTH_WORDS(64)) DUT (.clk(clk), .rst_b(rst_b), .k(k), .k_n(k_n),
        .load_strobe_n(load_strobe_n), .rd_wr(rd_wr), .addr(addr), .byte_write_select_n(byte_write_select_n),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .echo_clock(echo_clock), .echo_clock_n(echo_clock_n),
        .read_valid_flag(read_valid_flag));
    link_ctrl_model #(.WORD_W(W), .ADDR_W(5)) ctl (.clk(clk), .k(k), .k_n(k_n), .load_strobe_n(load_strobe_n),
        .rd_wr(rd_wr), .addr(addr), .byte_write_select_n(byte_write_select_n), .dq_drv(dq_drv),
        .dq_out(dq_out), .dq_oe(dq_oe), .read_valid_flag(read_valid_flag));
    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("errors %0d checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [35:0] exp, input logic twice);
        logic [35:0] d;
        logic [2:0] st;
        ctl.rd(a, twice, d, st);
        check(d, exp);
        check(36'(st), 36'h6);
    endtask
    task automatic t_reset();
        check(36'({dq_out, dq_oe, read_valid_flag, echo_clock, echo_clock_n}), 36'h0);
    endtask
    task automatic t_wr_rd();
        ctl.wr(5'h00, 36'h2_5a5a_1234, 2'h0, 2'h0);
        ctl.wr(5'h1f, 36'hc_0ffe_e5a5, 2'h0, 2'h0);
        rd_chk(5'h00, 36'h2_5a5a_1234, 1'b0);
        rd_chk(5'h1f, 36'hc_0ffe_e5a5, 1'b0);
    endtask
    task automatic t_bytes();
        logic [35:0] exp;
        logic [35:0] nw;
        logic [3:0] s;
        exp = '0;
        ctl.wr(5'h05, exp, 2'h0, 2'h0);
        for (int i = 0; i < 4; i++)
        begin
            s = {~2'(i), 2'(i)};
            nw = {4{9'h0a5 + 9'(i)}};
            ctl.wr(5'h05, nw, s[1:0], s[3:2]);
            for (int b = 0; b < 4; b++)
                if (!s[b])
                    exp[b*9 +: 9] = nw[b*9 +: 9];
            rd_chk(5'h05, exp, 1'b0);
        end
    endtask
    task automatic t_refuse();
        ctl.wr(5'h09, 36'h3_1111_2222, 2'h0, 2'h0);
        ctl.wr(5'h0a, 36'h4_3333_4444, 2'h0, 2'h0);
        rd_chk(5'h09, 36'h3_1111_2222, 1'b1);
    endtask
    initial
    begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    // a whole burst is about 60 clocks; ceiling leaves ample margin
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            err_count++;
            end_sim();
        end
    end
    initial
    begin
        rst_b = 0;
        repeat (3) @(posedge clk);
        t_reset();
        @(negedge clk);
        rst_b = 1;
        repeat (30) @(negedge clk);
        t_wr_rd();
        t_bytes();
        t_refuse();
        end_sim();
    end
endmodule
